// File: design/can_wake_id_mask_upper.sv
`timescale 1ns/10ps
`default_nettype none
module can_wake_id_mask_upper (
	// Clock and resets
	input wire logic clock,
	input wire logic rst_n,
	input wire logic soft_reset,
	input wire logic restart,
	// Register access
	input wire wake_mask_pkg::reg_req_type reg_req,
	output logic [wake_mask_pkg::DATA_W-1:0] reg_rdata,
	output logic reg_rvalid,
	// Frame comparison
	input wire logic [wake_mask_pkg::DATA_W-1:0] wake_id_value_high,
	input wire wake_mask_pkg::rx_id_type rx_id,
	output logic [wake_mask_pkg::DATA_W-1:0] id_compare_enable,
	output logic id_high_match,
	output logic id_high_match_valid
);

	logic [wake_mask_pkg::DATA_W-1:0] mask_r;
	logic [wake_mask_pkg::DATA_W-1:0] mask_nxt;
	logic [wake_mask_pkg::DATA_W-1:0] rdata_r;
	logic [wake_mask_pkg::DATA_W-1:0] rdata_nxt;
	logic rvalid_r;
	logic rvalid_nxt;
	logic match_r;
	logic match_nxt;
	logic mvalid_r;
	logic mvalid_nxt;
	logic cmp_match;
	logic hit;
	// Only the checks read this; the comparator works bit by bit
	logic [wake_mask_pkg::DATA_W-1:0] id_diff;

	assign hit = (reg_req.addr == wake_mask_pkg::WAKE_ID_MASK_HIGH_ADDR);
	assign id_diff = rx_id.id_high ^ wake_id_value_high;

	wake_id_compare #(
		.WIDTH(wake_mask_pkg::DATA_W)
	) u_cmp (
		.rx_id(rx_id.id_high),
		.ref_id(wake_id_value_high), // R6
		.compare_enable(mask_r),
		.match(cmp_match)
	);

	always_comb begin
		mask_nxt = mask_r; // R5
		if (soft_reset) begin
			mask_nxt = wake_mask_pkg::WAKE_ID_MASK_HIGH_RESET; // R4
		end else if (reg_req.wr_en && hit) begin
			mask_nxt = reg_req.wdata; // R1 R7
		end
		// Restart is deliberately not decoded here so the mask survives it
	end

	always_comb begin
		rdata_nxt = rdata_r;
		rvalid_nxt = 1'b0;
		if (reg_req.rd_en) begin
			rvalid_nxt = 1'b1;
			// Unmapped addresses read as zero
			rdata_nxt = hit ? mask_r : wake_mask_pkg::READ_ZERO; // R7
		end
	end

	always_comb begin
		mvalid_nxt = rx_id.valid;
		match_nxt = match_r;
		if (rx_id.valid) begin
			match_nxt = cmp_match; // R2 R3
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			mask_r <= wake_mask_pkg::WAKE_ID_MASK_HIGH_RESET; // R4
		end else begin
			mask_r <= mask_nxt;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rdata_r <= wake_mask_pkg::READ_ZERO;
			rvalid_r <= 1'b0;
		end else begin
			rdata_r <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			match_r <= 1'b0;
			mvalid_r <= 1'b0;
		end else begin
			match_r <= match_nxt;
			mvalid_r <= mvalid_nxt;
		end
	end

	assign id_compare_enable = mask_r;
	assign reg_rdata = rdata_r;
	assign reg_rvalid = rvalid_r;
	assign id_high_match = match_r;
	assign id_high_match_valid = mvalid_r;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	mask_write_update_a: assert property (reg_req.wr_en && hit && !soft_reset |=> mask_r == $past(reg_req.wdata)) // R1
		else $error("mask not loaded by write");
	mask_dontcare_a: assert property (rx_id.valid && (id_diff & mask_r) == 16'h0000 // R2
		|=> id_high_match && id_high_match_valid)
		else $error("masked-off bits affected the match");
	mask_compare_a: assert property (rx_id.valid && (id_diff & mask_r) != 16'h0000 // R3
		|=> !id_high_match && id_high_match_valid)
		else $error("enabled bit mismatch not detected");
	soft_clear_a: assert property (soft_reset |=> mask_r == 16'h0000 && id_compare_enable == 16'h0000) // R4
		else $error("soft reset did not clear mask");
	// Reset must be checked while it is applied, so the default disable is overridden
	por_clear_a: assert property (disable iff (1'b0) !rst_n // R4
		|=> id_compare_enable == 16'h0000 && reg_rdata == 16'h0000 && !reg_rvalid
		&& !id_high_match && !id_high_match_valid)
		else $error("power-on reset did not clear the outputs");
	restart_write_a: assert property (restart && reg_req.wr_en && hit && !soft_reset // R7
		|=> mask_r == $past(reg_req.wdata))
		else $error("write during restart was lost");
	restart_keep_a: assert property (restart && !soft_reset && !(reg_req.wr_en && hit) |=> $stable(mask_r)) // R5
		else $error("restart changed the mask");
	ref_source_a: assert property (rx_id.valid && mask_r == 16'hffff // R6
		|=> id_high_match == ($past(rx_id.id_high) == $past(wake_id_value_high)))
		else $error("reference not taken from identifier value");
	read_back_a: assert property (reg_req.rd_en && hit |=> reg_rvalid && reg_rdata == $past(mask_r)) // R7
		else $error("read did not return stored mask");
	unmapped_zero_a: assert property (reg_req.rd_en && !hit |=> reg_rvalid && reg_rdata == 16'h0000)
		else $error("unmapped read not zero");
	write_hold_a: assert property (!(reg_req.wr_en && hit) && !soft_reset |=> $stable(mask_r)) // R7
		else $error("mask changed without a write");
	rvalid_pulse_a: assert property (!reg_req.rd_en |=> !reg_rvalid) // R7
		else $error("read valid without a read");
	rdata_hold_a: assert property (!reg_req.rd_en |=> $stable(reg_rdata)) // R7
		else $error("read data moved without a read");
	match_pulse_a: assert property (!rx_id.valid |=> !id_high_match_valid) // R3
		else $error("match valid without a frame");
	match_hold_a: assert property (!rx_id.valid |=> $stable(id_high_match)) // R3
		else $error("match result moved without a frame");

	// A lone differing bit shows which mask bit governs it
	for (genvar g = 0; g < wake_mask_pkg::DATA_W; g++) begin : g_bit_chk
		single_bit_a: assert property (rx_id.valid && id_diff == (16'h0001 << g) // R1
			|=> id_high_match == !$past(mask_r[g]))
			else $error("mask bit does not govern its identifier bit");
	end

	write_then_read_c: cover property (reg_req.wr_en && hit ##2 reg_req.rd_en && hit);
	partial_match_c: cover property (rx_id.valid && mask_r != 16'h0000 && mask_r != 16'hffff && cmp_match);
	restart_held_c: cover property (restart && mask_r != 16'h0000 ##1 mask_r != 16'h0000);
	soft_clear_c: cover property (soft_reset && mask_r != 16'h0000);
	soft_over_write_c: cover property (soft_reset && reg_req.wr_en && hit);

endmodule
`default_nettype wire

// File: design/wake_mask_pkg.sv
// Notes on behaviour
// R1: A 16-bit read/write mask register sits at address 011 0100, bit 15 covering identifier bit 28 down to bit 0 covering bit 13.
// R2: A mask bit at 0 makes the matching identifier bit of a received frame a don't-care in the wake-up comparison.
// R3: A mask bit at 1 requires the received identifier bit to equal the programmed wake-up identifier bit.
// R4: Power-on or soft reset clears all sixteen mask bits to zero.
// R5: A restart-type reset leaves every mask bit at its previous value.
// R6: The reference bits for the comparison come bit for bit from the wake-up identifier register at 011 0010.
// R7: A write updates all sixteen mask bits at once and a read returns the stored mask unchanged.
`default_nettype none
package wake_mask_pkg;

	localparam int ADDR_W = 7;
	localparam int DATA_W = 16;
	localparam logic [ADDR_W-1:0] WAKE_ID_MASK_HIGH_ADDR = 7'h34;
	localparam logic [DATA_W-1:0] WAKE_ID_MASK_HIGH_RESET = 16'h0000;
	localparam logic [DATA_W-1:0] READ_ZERO = 16'h0000;
	// Bit 15 of the register covers identifier bit 28
	localparam int TOP_ID_BIT = 28;
	localparam int LOW_ID_BIT = 13;

	typedef struct packed {
		logic wr_en;
		logic rd_en;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} reg_req_type;

	typedef struct packed {
		logic valid;
		logic [DATA_W-1:0] id_high;
	} rx_id_type;

endpackage
`default_nettype wire

// File: design/wake_id_compare.sv
`timescale 1ns/10ps
`default_nettype none
module wake_id_compare #(
	parameter int WIDTH = 16
) (
	// Operands
	input wire logic [WIDTH-1:0] rx_id,
	input wire logic [WIDTH-1:0] ref_id,
	input wire logic [WIDTH-1:0] compare_enable,
	// Result
	output logic match
);

	logic [WIDTH-1:0] bit_ok;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			// Disabled bits always pass
			assign bit_ok[i] = ~compare_enable[i] | ~(rx_id[i] ^ ref_id[i]); // R2 R3
		end
	endgenerate

	assign match = &bit_ok;

endmodule
`default_nettype wire

// File: verification/can_wake_id_mask_upper_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module can_wake_id_mask_upper_tb_top;
	localparam logic [6:0] MA = wake_mask_pkg::WAKE_ID_MASK_HIGH_ADDR;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic soft_reset = 1'b0;
	logic restart = 1'b0;
	wake_mask_pkg::reg_req_type reg_req = '0;
	wake_mask_pkg::rx_id_type rx_id = '0;
	logic [15:0] wake_id_value_high = 16'h0000;
	logic [15:0] reg_rdata, id_compare_enable;
	logic reg_rvalid, id_high_match, id_high_match_valid;
	int n_errors = 0;
	int num_checks = 0;
	always #4 clock = ~clock;
	can_wake_id_mask_upper dut_u (.clock(clock), .rst_n(rst_n), .soft_reset(soft_reset), .restart(restart),
		.reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.wake_id_value_high(wake_id_value_high), .rx_id(rx_id), .id_compare_enable(id_compare_enable),
		.id_high_match(id_high_match), .id_high_match_valid(id_high_match_valid));
	// Inputs always move 1 ns after the rising edge
	task tick;
		@(posedge clock);
		#1;
	endtask
	task check(input logic [15:0] got, input logic [15:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %s", $time, what);
		end
	endtask
	task check_flag(input logic got, input logic exp, input string what);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %s", $time, what);
		end
	endtask
	// The idle edge at the end keeps a strobe from being lowered and raised in one time step
	task wr(input logic [6:0] a, input logic [15:0] d);
		reg_req.wr_en = 1'b1;
		reg_req.addr = a;
		reg_req.wdata = d;
		tick;
		reg_req.wr_en = 1'b0;
		tick;
	endtask
	task rd(input logic [6:0] a, input logic [15:0] e);
		reg_req.rd_en = 1'b1;
		reg_req.addr = a;
		tick;
		reg_req.rd_en = 1'b0;
		check_flag(reg_rvalid, 1'b1, "read valid");
		check(reg_rdata, e, "read data");
		tick;
		check_flag(reg_rvalid, 1'b0, "read valid pulse");
		check(reg_rdata, e, "read data hold");
	endtask
	task cmp(input logic [15:0] id, input logic e);
		rx_id.valid = 1'b1;
		rx_id.id_high = id;
		tick;
		rx_id.valid = 1'b0;
		check_flag(id_high_match_valid, 1'b1, "match valid");
		check_flag(id_high_match, e, "match result");
		tick;
		check_flag(id_high_match_valid, 1'b0, "match valid pulse");
		check_flag(id_high_match, e, "match result hold");
	endtask
	task print_verdict;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// The tests need well under 100 cycles; 3 us leaves ample margin
	initial begin
		#3000;
		n_errors++;
		print_verdict;
	end
	initial begin
		repeat (10) tick;
		rst_n = 1'b1;
		rd(MA, 16'h0000);
		check(id_compare_enable, 16'h0000, "mask after reset");
		wr(MA, 16'hA5C3);
		check(id_compare_enable, 16'hA5C3, "mask output");
		rd(MA, 16'hA5C3);
		rd(7'h35, 16'h0000);
		// Neighbouring identifier address must not land here
		wr(7'h32, 16'hFFFF);
		rd(MA, 16'hA5C3);
		wr(MA, 16'h8001);
		wake_id_value_high = 16'h8001;
		cmp(16'h8001, 1'b1);
		cmp(16'hFFFF, 1'b1);
		cmp(16'h0001, 1'b0);
		cmp(16'h8000, 1'b0);
		wake_id_value_high = 16'h0000;
		cmp(16'h8001, 1'b0);
		cmp(16'h7FFE, 1'b1);
		restart = 1'b1;
		tick;
		tick;
		restart = 1'b0;
		rd(MA, 16'h8001);
		restart = 1'b1;
		wr(MA, 16'hFFFF);
		restart = 1'b0;
		check(id_compare_enable, 16'hFFFF, "write during restart");
		wake_id_value_high = 16'h1234;
		cmp(16'h1234, 1'b1);
		cmp(16'h1235, 1'b0);
		soft_reset = 1'b1;
		tick;
		soft_reset = 1'b0;
		rd(MA, 16'h0000);
		cmp(16'hEDCB, 1'b1);
		wr(MA, 16'h3C3C);
		// Soft reset must win over a write in the same cycle
		soft_reset = 1'b1;
		wr(MA, 16'h5555);
		soft_reset = 1'b0;
		rd(MA, 16'h0000);
		wr(MA, 16'h3C3C);
		rst_n = 1'b0;
		tick;
		rst_n = 1'b1;
		rd(MA, 16'h0000);
		check(id_compare_enable, 16'h0000, "mask after second reset");
		print_verdict;
	end
endmodule
`default_nettype wire
